/* File: rtl/drive_uart.sv */
`timescale 1ns/100ps
module drive_uart #(
   parameter int unsigned BIT_CYCLES = fbs_pkg::BIT_CYCLES
) (
   input  wire logic   core_clk,
   input  wire logic   resetn,
   drive_link_if.uart  link,
   input  wire logic   drive_rx,
   output logic        drive_tx
);

   typedef struct packed {
      logic                           rx_m;     // Sync stage one
      logic                           rx_s;     // Sync stage two
      logic                           rx_busy;  // Receiving a frame
      logic [fbs_pkg::BIT_CNT_W-1:0]  rx_timer; // Bit timer
      logic [3:0]                     rx_idx;   // Sample index
      logic [9:0]                     rx_shift; // Data plus stops
      logic [7:0]                     rx_data;  // Captured byte
      logic                           rx_strobe;
      logic                           rx_error;
      logic                           tx_busy;
      logic [fbs_pkg::BIT_CNT_W-1:0]  tx_timer;
      logic [3:0]                     tx_left;  // Bits still to send
      logic [9:0]                     tx_shift;
      logic                           tx_line;
   } uart_state_s;

   uart_state_s r;
   uart_state_s n;

   localparam logic [fbs_pkg::BIT_CNT_W-1:0] BIT_LAST = fbs_pkg::BIT_CNT_W'(BIT_CYCLES - 1);
   localparam logic [fbs_pkg::BIT_CNT_W-1:0] HALF_BIT = fbs_pkg::BIT_CNT_W'(BIT_CYCLES / 2);

   // Next-state logic for both directions
   always_comb begin
      n = r;
      n.rx_m = drive_rx;
      n.rx_s = r.rx_m;
      n.rx_strobe = 1'b0;
      if (!r.rx_busy) begin
         // Start edge seen on synchronised line
         if (!r.rx_s) begin
            n.rx_busy = 1'b1;
            n.rx_timer = HALF_BIT;
            n.rx_idx = 4'h0;
         end
      end else if (r.rx_timer != '0) begin
         n.rx_timer = r.rx_timer - 1'b1;
      end else begin
         n.rx_timer = BIT_LAST;
         if (r.rx_idx == 4'h0) begin
            // Glitch rather than start bit
            if (r.rx_s) begin
               n.rx_busy = 1'b0;
            end
         end else begin
            n.rx_shift = {r.rx_s, r.rx_shift[9:1]};
         end
         n.rx_idx = r.rx_idx + 1'b1;
         if (r.rx_idx == 4'ha) begin
            n.rx_busy = 1'b0;
            n.rx_strobe = 1'b1;
            n.rx_data = n.rx_shift[7:0];
            n.rx_error = ~&n.rx_shift[9:8];
         end
      end
      if (!r.tx_busy) begin
         n.tx_line = 1'b1;
         if (link.tx_start) begin
            n.tx_busy = 1'b1;
            n.tx_line = 1'b0;
            n.tx_shift = {2'b11, link.tx_data};
            n.tx_left = 4'ha;
            n.tx_timer = BIT_LAST;
         end
      end else if (r.tx_timer != '0) begin
         n.tx_timer = r.tx_timer - 1'b1;
      end else if (r.tx_left == 4'h0) begin
         // Last stop bit served
         n.tx_busy = 1'b0;
         n.tx_line = 1'b1;
      end else begin
         n.tx_line = r.tx_shift[0];
         n.tx_shift = {1'b1, r.tx_shift[9:1]};
         n.tx_left = r.tx_left - 1'b1;
         n.tx_timer = BIT_LAST;
      end
   end

   // State register, idle line high
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.rx_m <= 1'b1;
         r.rx_s <= 1'b1;
         r.tx_line <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign link.tx_busy   = r.tx_busy;
   assign link.rx_data   = r.rx_data;
   assign link.rx_strobe = r.rx_strobe;
   assign link.rx_error  = r.rx_error;
   assign drive_tx       = r.tx_line;

   tx_stop_high_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.tx_busy && r.tx_left <= 4'h1) |-> r.tx_line)
      else $error("Stop bit not driven high");

   bit_timer_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $fell(r.tx_busy) |-> $past(r.tx_timer) == '0 && $past(r.tx_left) == 4'h0)
      else $error("Frame ended before last bit period");

endmodule

/* File: rtl/fieldbus_address_startup_ctrl.sv */
// Function
// - Address is high nibble over low nibble
// - Only the switches set the address
// - 1..0x7D valid, 0 and 0x7E..0xFE invalid
// - Both switches F enter self-test
// - Self-test holds both indicators orange
// - Switches sampled once after power-up
// - Drive link frames 8 data, none, 2 stop
// - Drive link runs at 9600 bit/s
// - Both indicators orange during initialisation
// - Drive indicator green once link up
// - Each indicator shows its own link
// - Fieldbus rate 9.6 kbaud to 12 Mbaud
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module fieldbus_address_startup_ctrl #(
   parameter int unsigned BIT_CYCLES  = fbs_pkg::BIT_CYCLES,
   parameter int unsigned INIT_CYCLES = fbs_pkg::INIT_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  address_switch_high,
   input  wire logic [3:0]  address_switch_low,
   input  wire logic        fieldbus_online,
   input  wire logic        drive_rx,
   output logic             drive_tx,
   output logic [1:0]       drive_link_indicator,
   output logic [1:0]       fieldbus_indicator,
   output logic [7:0]       node_address,
   output logic             fieldbus_enable,
   output logic [3:0]       fieldbus_rate,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   // Whole controller state in one word
   typedef struct packed {
      logic [3:0]                      sw_hi_m;   // Switch sync stage one
      logic [3:0]                      sw_hi_s;   // Switch sync stage two
      logic [3:0]                      sw_lo_m;
      logic [3:0]                      sw_lo_s;
      logic                            fb_on_m;   // Fieldbus status sync
      logic                            fb_on_s;
      fbs_pkg::mode_e                  mode;      // Start-up sequencer
      logic [fbs_pkg::INIT_CNT_W-1:0]  init_cnt;  // Initialisation timer
      logic [7:0]                      node_addr; // Latched node address
      logic                            link_up;   // Drive answered once
      logic [1:0]                      drive_ind;
      logic [1:0]                      fb_ind;
      logic                            fb_enable;
      logic [3:0]                      fb_rate;
      logic [7:0]                      tx_data;
      logic                            tx_start;
      logic [7:0]                      rx_byte;
      logic                            rx_full;
      logic                            rx_err;
      logic                            ack;
      logic [31:0]                     dat;
   } ctrl_state_s;

   ctrl_state_s r;
   ctrl_state_s n;

   // Last count of the initialisation timer
   localparam logic [fbs_pkg::INIT_CNT_W-1:0] INIT_LAST = fbs_pkg::INIT_CNT_W'(INIT_CYCLES - 1);

   drive_link_if link ();  // Carrier to the serial engine

   // Serial engine toward the drive
   // Fixed drive rate
   drive_uart #(
      .BIT_CYCLES (BIT_CYCLES)
   ) u_uart (
      .core_clk (core_clk),
      .resetn   (resetn),
      .link     (link.uart),
      .drive_rx (drive_rx),
      .drive_tx (drive_tx)
   );

   assign link.tx_data  = r.tx_data;
   assign link.tx_start = r.tx_start;

   // Combined switch value as seen now
   logic [7:0] sw_value;
   // Request accepted this cycle
   logic       wb_req;
   // Read word for the current address
   logic [31:0] rd_word;

   assign sw_value = {r.sw_hi_s, r.sw_lo_s};
   assign wb_req   = wb_cyc_i && wb_stb_i && !r.ack;

   // Read multiplexer, unmapped reads as zero
   always_comb begin
      rd_word = 32'h0;
      case (wb_adr_i[7:2])
         fbs_pkg::ADR_STATUS[7:2]: begin
            rd_word[fbs_pkg::ST_VALID_BIT]    = (r.mode == fbs_pkg::ST_RUN);
            rd_word[fbs_pkg::ST_TEST_BIT]     = (r.mode == fbs_pkg::ST_TEST);
            rd_word[fbs_pkg::ST_INITDONE_BIT] = (r.mode != fbs_pkg::ST_INIT);
            rd_word[fbs_pkg::ST_LINK_BIT]     = r.link_up;
            rd_word[fbs_pkg::ST_FBON_BIT]     = r.fb_on_s;
            rd_word[fbs_pkg::ST_TXBUSY_BIT]   = link.tx_busy;
            rd_word[fbs_pkg::ST_ADDR_LSB +: 8] = r.node_addr;
            rd_word[fbs_pkg::ST_RATE_LSB +: 4] = r.fb_rate;
         end
         fbs_pkg::ADR_CONTROL[7:2]: begin
            rd_word[fbs_pkg::CTL_RATE_LSB +: 4] = r.fb_rate;
         end
         fbs_pkg::ADR_RXDATA[7:2]: begin
            rd_word[fbs_pkg::RX_DATA_LSB +: 8] = r.rx_byte;
            rd_word[fbs_pkg::RX_FULL_BIT]      = r.rx_full;
            rd_word[fbs_pkg::RX_ERR_BIT]       = r.rx_err;
         end
         default: begin
            rd_word = 32'h0;
         end
      endcase
   end

   // Next-state logic: sync, sequencer, indicators, bus slave
   always_comb begin
      n = r;
      // Two-stage synchronisers for pins
      n.sw_hi_m = address_switch_high;
      n.sw_hi_s = r.sw_hi_m;
      n.sw_lo_m = address_switch_low;
      n.sw_lo_s = r.sw_lo_m;
      n.fb_on_m = fieldbus_online;
      n.fb_on_s = r.fb_on_m;
      n.tx_start = 1'b0;
      n.ack = 1'b0;

      // Start-up sequencer
      case (r.mode)
         fbs_pkg::ST_INIT: begin
            // Counting through the self-check window
            if (r.init_cnt >= INIT_LAST) begin
               n.node_addr = sw_value;
               if (sw_value == fbs_pkg::ADDR_TEST) begin
                  n.mode = fbs_pkg::ST_TEST;
               end else if (sw_value >= fbs_pkg::ADDR_MIN && sw_value <= fbs_pkg::ADDR_MAX) begin
                  n.mode = fbs_pkg::ST_RUN;
                  n.fb_enable = 1'b1;
               end else begin
                  n.mode = fbs_pkg::ST_OFFLINE;
               end
            end else begin
               n.init_cnt = r.init_cnt + 1'b1;
            end
         end
         fbs_pkg::ST_TEST: begin
            // Terminal until power cycle
            n.mode = fbs_pkg::ST_TEST;
         end
         fbs_pkg::ST_RUN: begin
            // Address stays latched while running
            n.mode = fbs_pkg::ST_RUN;
         end
         fbs_pkg::ST_OFFLINE: begin
            // No way out but a power cycle
            n.mode = fbs_pkg::ST_OFFLINE;
            n.fb_enable = 1'b0;
         end
         default: begin
            // Illegal code, restart the sequence
            n.mode = fbs_pkg::ST_INIT;
            n.init_cnt = '0;
            n.fb_enable = 1'b0;
         end
      endcase

      // Drive link counts as up after one clean byte
      if (n.mode != fbs_pkg::ST_INIT && n.mode != fbs_pkg::ST_TEST) begin
         if (link.rx_strobe && !link.rx_error) begin
            n.link_up = 1'b1;
         end
      end

      // Indicator colours follow the next state
      case (n.mode)
         fbs_pkg::ST_INIT: begin
            n.drive_ind = fbs_pkg::IND_ORANGE;
            n.fb_ind = fbs_pkg::IND_ORANGE;
         end
         fbs_pkg::ST_TEST: begin
            n.drive_ind = fbs_pkg::IND_ORANGE;
            n.fb_ind = fbs_pkg::IND_ORANGE;
         end
         fbs_pkg::ST_RUN: begin
            n.drive_ind = n.link_up ? fbs_pkg::IND_GREEN : fbs_pkg::IND_RED;
            n.fb_ind = r.fb_on_s ? fbs_pkg::IND_GREEN : fbs_pkg::IND_RED;
         end
         default: begin
            // Offline: drive side still reported
            n.drive_ind = n.link_up ? fbs_pkg::IND_GREEN : fbs_pkg::IND_RED;
            n.fb_ind = fbs_pkg::IND_RED;
         end
      endcase

      // Wishbone slave, ack one cycle after request
      if (wb_req) begin
         n.ack = 1'b1;
         n.dat = wb_we_i ? 32'h0 : rd_word;
         if (wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i[7:2])
               fbs_pkg::ADR_CONTROL[7:2]: begin
                  if (wb_dat_i[fbs_pkg::CTL_RATE_LSB +: 4] <= fbs_pkg::FB_RATE_MAX) begin
                     n.fb_rate = wb_dat_i[fbs_pkg::CTL_RATE_LSB +: 4];
                  end
               end
               fbs_pkg::ADR_TXDATA[7:2]: begin
                  // Dropped while a frame is in flight
                  if (!link.tx_busy && !r.tx_start) begin
                     n.tx_data = wb_dat_i[7:0];
                     n.tx_start = 1'b1;
                  end
               end
               default: begin
                  n.node_addr = r.node_addr;
               end
            endcase
         end else if (!wb_we_i && wb_adr_i[7:2] == fbs_pkg::ADR_RXDATA[7:2]) begin
            // Reading the byte frees the holding slot
            n.rx_full = 1'b0;
         end
      end

      // New byte after the clear so the set wins
      if (link.rx_strobe) begin
         n.rx_byte = link.rx_data;
         n.rx_err = link.rx_error;
         n.rx_full = 1'b1;
      end
   end

   // State register, starts in initialisation
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.mode <= fbs_pkg::ST_INIT;
         r.drive_ind <= fbs_pkg::IND_ORANGE;
         r.fb_ind <= fbs_pkg::IND_ORANGE;
         r.fb_rate <= fbs_pkg::FB_RATE_RST;
      end else begin
         r <= n;
      end
   end

   assign drive_link_indicator = r.drive_ind;
   assign fieldbus_indicator   = r.fb_ind;
   assign node_address         = r.node_addr;
   assign fieldbus_enable      = r.fb_enable;
   assign fieldbus_rate        = r.fb_rate;
   assign wb_dat_o             = r.dat;
   assign wb_ack_o             = r.ack;

   addr_valid_range_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_RUN) |-> (r.node_addr >= 8'h01 && r.node_addr <= 8'h7d && r.fb_enable))
      else $error("Running with address outside valid range");

   test_entry_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode != fbs_pkg::ST_INIT) |-> ((r.mode == fbs_pkg::ST_TEST) == (r.node_addr == 8'hff)))
      else $error("Self-test state does not match address FF");

   test_orange_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_TEST) |-> (drive_link_indicator == 2'h3 && fieldbus_indicator == 2'h3
                                         && !fieldbus_enable))
      else $error("Self-test indicators not orange");

   addr_frozen_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode != fbs_pkg::ST_INIT) |=> ($stable(node_address) && r.mode != fbs_pkg::ST_INIT))
      else $error("Node address changed after power-up sample");

   addr_no_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (wb_req && wb_we_i && r.mode != fbs_pkg::ST_INIT) |=> $stable(node_address))
      else $error("Bus write altered node address");

   init_orange_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_INIT) |-> (drive_link_indicator == 2'h3 && fieldbus_indicator == 2'h3))
      else $error("Indicators not orange during initialisation");

   link_green_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_RUN && link.rx_strobe && !link.rx_error) |=> (drive_link_indicator == 2'h1))
      else $error("Drive indicator not green after link up");

   fb_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_RUN && $past(r.mode) == fbs_pkg::ST_RUN)
         |-> (fieldbus_indicator == ($past(r.fb_on_s) ? 2'h1 : 2'h2)))
      else $error("Fieldbus indicator does not follow status");

   rate_range_a: assert property (@(posedge core_clk) disable iff (!resetn)
      fieldbus_rate <= 4'h9)
      else $error("Unsupported fieldbus rate code");

   offline_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (r.mode == fbs_pkg::ST_OFFLINE) |-> (!fieldbus_enable && fieldbus_indicator == 2'h2) [*2])
      else $error("Offline node enabled on fieldbus");

   // Bus ack lasts one cycle
   bus_ack_once_a: assert property (@(posedge core_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");

endmodule

/* File: shared/drive_link_if.sv */
`timescale 1ns/100ps
interface drive_link_if;
   logic [7:0] tx_data;   // Byte to send
   logic       tx_start;  // One-cycle send request
   logic       tx_busy;   // Frame in progress
   logic [7:0] rx_data;   // Last received byte
   logic       rx_strobe; // One-cycle receive pulse
   logic       rx_error;  // Stop bit fault with strobe

   modport ctrl (output tx_data, tx_start, input tx_busy, rx_data, rx_strobe, rx_error);
   modport uart (input tx_data, tx_start, output tx_busy, rx_data, rx_strobe, rx_error);
endinterface

/* File: shared/fbs_pkg.sv */
package fbs_pkg;

   // Core clock rate
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned CLK_MHZ         = 125;
   // Drive link serial rate in bit/s
   localparam int unsigned DRIVE_BAUD      = 9600;
   // Cycles per serial bit, rounded down
   localparam int unsigned BIT_CYCLES      = CLK_HZ / DRIVE_BAUD;
   // Power-up initialisation and self-check time in microseconds
   localparam int unsigned INIT_TIME_US    = 1000;
   localparam int unsigned INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
   // Counter widths sized for the default counts
   localparam int unsigned BIT_CNT_W       = 14;
   localparam int unsigned INIT_CNT_W      = 17;

   // Register byte offsets
   localparam logic [7:0] ADR_STATUS       = 8'h00;
   localparam logic [7:0] ADR_CONTROL      = 8'h04;
   localparam logic [7:0] ADR_TXDATA       = 8'h08;
   localparam logic [7:0] ADR_RXDATA       = 8'h0c;

   // Status field positions
   localparam int unsigned ST_VALID_BIT    = 0;
   localparam int unsigned ST_TEST_BIT     = 1;
   localparam int unsigned ST_INITDONE_BIT = 2;
   localparam int unsigned ST_LINK_BIT     = 3;
   localparam int unsigned ST_FBON_BIT     = 4;
   localparam int unsigned ST_TXBUSY_BIT   = 5;
   localparam int unsigned ST_ADDR_LSB     = 8;
   localparam int unsigned ST_RATE_LSB     = 16;
   // Receive data field positions
   localparam int unsigned RX_DATA_LSB     = 0;
   localparam int unsigned RX_FULL_BIT     = 8;
   localparam int unsigned RX_ERR_BIT      = 9;
   // Control field position
   localparam int unsigned CTL_RATE_LSB    = 0;

   // Fieldbus rate codes, 9.6 kbaud up to 12 Mbaud
   localparam logic [3:0] FB_RATE_RST      = 4'h0;
   localparam logic [3:0] FB_RATE_MAX      = 4'h9;

   // Node address classes
   localparam logic [7:0] ADDR_MIN         = 8'h01;
   localparam logic [7:0] ADDR_MAX         = 8'h7d;
   localparam logic [7:0] ADDR_TEST        = 8'hff;

   // Indicator colour codes, bit 0 green, bit 1 red
   localparam logic [1:0] IND_OFF          = 2'h0;
   localparam logic [1:0] IND_GREEN        = 2'h1;
   localparam logic [1:0] IND_RED          = 2'h2;
   localparam logic [1:0] IND_ORANGE       = 2'h3;

   // Start-up sequencer states
   typedef enum logic [3:0] {
      ST_INIT    = 4'b0001,
      ST_TEST    = 4'b0010,
      ST_RUN     = 4'b0100,
      ST_OFFLINE = 4'b1000
   } mode_e;

endpackage

/* File: verif/drive_model.sv */
`timescale 1ns/100ps
// Drive end of the serial link: sends one byte on request
module drive_model #(
   parameter int unsigned BIT_CYCLES = 16
) (
   input  wire logic       core_clk,
   input  wire logic       send,
   input  wire logic [7:0] data,
   output logic            drive_rx
);
   // Line rests high, as a biased receiver would see it
   initial drive_rx = 1'b1;
   always @(posedge core_clk) begin
      if (send) begin
         drive_rx <= 1'b0;
         repeat (BIT_CYCLES) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            drive_rx <= data[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
         end
         drive_rx <= 1'b1;
         repeat (2 * BIT_CYCLES) @(posedge core_clk);
      end
   end
endmodule

/* File: verif/test_fieldbus_address_startup_ctrl.sv */
`timescale 1ns/100ps
module test_fieldbus_address_startup_ctrl;
   localparam int unsigned BITC  = 16;  // Short bit time
   localparam int unsigned INITC = 20;  // Short init
   logic        core_clk = 1'b0;
   logic        resetn   = 1'b0;
   logic [3:0]  sw_h     = 4'h0;
   logic [3:0]  sw_l     = 4'h0;
   logic        fb_on    = 1'b0;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [31:0] dat_w    = 32'h0;
   logic        send     = 1'b0;
   logic [7:0]  sdata    = 8'h00;
   logic        drive_rx;
   logic        drive_tx;
   logic [1:0]  dli;
   logic [1:0]  fbi;
   logic [7:0]  node_address;
   logic        fieldbus_enable;
   logic [3:0]  fieldbus_rate;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [31:0] rd;
   int          error_cnt   = 0;
   int          comparisons = 0;

   // 125 MHz
   always #4 core_clk = ~core_clk;

   fieldbus_address_startup_ctrl #(.BIT_CYCLES(BITC), .INIT_CYCLES(INITC)) fieldbus_address_startup_ctrl_inst (
      .core_clk(core_clk), .resetn(resetn), .address_switch_high(sw_h), .address_switch_low(sw_l),
      .fieldbus_online(fb_on), .drive_rx(drive_rx), .drive_tx(drive_tx), .drive_link_indicator(dli),
      .fieldbus_indicator(fbi), .node_address(node_address), .fieldbus_enable(fieldbus_enable),
      .fieldbus_rate(fieldbus_rate), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   drive_model #(.BIT_CYCLES(BITC)) drive_model_inst (
      .core_clk(core_clk), .send(send), .data(sdata), .drive_rx(drive_rx));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task end_of_test;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         end_of_test();
      end
   endtask

   // Power cycle with given switches, then wait out init
   task automatic pwr(input logic [7:0] a);
      @(posedge core_clk);
      resetn <= 1'b0;
      sw_h <= a[7:4];
      sw_l <= a[3:0];
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk({dli, fbi}, {fbs_pkg::IND_ORANGE, fbs_pkg::IND_ORANGE});
      repeat (INITC + 10) @(posedge core_clk);
   endtask

   task automatic t_class;
      logic [7:0] a [5];
      logic       ok;
      a = '{8'h00, 8'h01, 8'h7d, 8'h7e, 8'hfe};
      fb_on <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         pwr(a[i]);
         ok = (a[i] != 8'h00) && (a[i] < 8'h7e);
         chk(fieldbus_enable, ok);
         chk(fbi, ok ? fbs_pkg::IND_GREEN : fbs_pkg::IND_RED);
      end
      $display("address class test done");
   endtask

   task automatic t_valid;
      pwr(8'h3c);
      chk(node_address, 8'h3c);
      chk(dli, fbs_pkg::IND_RED);
      wb(1'b0, fbs_pkg::ADR_STATUS, 32'h0);
      chk(rd[15:8], 8'h3c);
      // Switches and bus writes must not move the address
      sw_h <= 4'h0;
      sw_l <= 4'h5;
      fb_on <= 1'b0;
      wb(1'b1, fbs_pkg::ADR_STATUS, 32'h0000_1100);
      repeat (10) @(posedge core_clk);
      chk(node_address, 8'h3c);
      wb(1'b0, fbs_pkg::ADR_STATUS, 32'h0);
      chk(rd[15:8], 8'h3c);
      chk(fbi, fbs_pkg::IND_RED);
      wb(1'b1, fbs_pkg::ADR_CONTROL, 32'h9);
      wb(1'b1, fbs_pkg::ADR_CONTROL, 32'ha);
      wb(1'b0, fbs_pkg::ADR_CONTROL, 32'h0);
      chk(rd, 32'h9);
      chk(fieldbus_rate, 4'h9);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      sdata <= 8'h96;
      send <= 1'b1;
      @(posedge core_clk);
      send <= 1'b0;
      repeat (12 * BITC) @(posedge core_clk);
      chk(dli, fbs_pkg::IND_GREEN);
      wb(1'b0, fbs_pkg::ADR_RXDATA, 32'h0);
      chk(rd[9:0], 10'h196);
      $display("valid address test done");
   endtask

   task automatic t_tx;
      int         n;
      logic [9:0] f;
      f = {2'b11, 8'h5a};
      wb(1'b1, fbs_pkg::ADR_TXDATA, 32'h5a);
      n = 0;
      while (drive_tx !== 1'b0 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      repeat (BITC / 2) @(posedge core_clk);
      chk(drive_tx, 1'b0);
      for (int i = 0; i < 10; i++) begin
         repeat (BITC) @(posedge core_clk);
         chk(drive_tx, f[i]);
      end
      $display("transmit test done");
   endtask

   task automatic t_test;
      fb_on <= 1'b1;
      pwr(8'hff);
      sdata <= 8'h33;
      send <= 1'b1;
      @(posedge core_clk);
      send <= 1'b0;
      repeat (12 * BITC) @(posedge core_clk);
      chk({dli, fbi}, {fbs_pkg::IND_ORANGE, fbs_pkg::IND_ORANGE});
      chk(fieldbus_enable, 1'b0);
      $display("self test done");
   endtask

   initial begin
      t_class();
      t_valid();
      t_tx();
      t_test();
      end_of_test();
   end
endmodule
